// ===== src/cpd_hold_timer.sv
// Counter that raises done once its input has stood high for a set number of cycles.
`default_nettype none
`timescale 1ns/10ps

module cpd_hold_timer #(
	parameter int CYCLES = 1
) (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic level,       // Condition that must hold.
	output var  logic done         // High once the condition held long enough.
);

	// ------------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------------
	logic [31:0] count_r;              // Cycles the condition has held.
	logic [31:0] count_nxt;            // Next count.
	logic        done_nxt;             // Next done level.
	wire  logic  reached;              // Count has reached its target.

	// The count saturates so done stays up for as long as the level holds.
	assign reached   = (count_r >= 32'(CYCLES - 1));
	assign count_nxt = !level ? 32'h0000_0000 : (reached ? count_r : count_r + 32'h0000_0001);
	assign done_nxt  = level && reached;

	// Any drop of the level restarts the wait from zero.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			count_r <= 32'h0000_0000;
			done    <= 1'b0;
		end else begin
			count_r <= count_nxt;
			done    <= done_nxt;
		end
	end

endmodule // cpd_hold_timer

`default_nettype wire

// ===== src/cpd_pkg.sv
// Package with the register map, field layout and timing of the codec power-down control.
`default_nettype none

package cpd_pkg;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [15:0] CPD_OFS_PD1 = 16'h1101;   // First power-down register.
	localparam logic [15:0] CPD_OFS_PD2 = 16'h1102;   // Second power-down register.
	localparam logic [15:0] CPD_OFS_PD3 = 16'h1103;   // Clock-stop and monitor register.

	// ------------------------------------------------------------------
	// Reset values and writable masks
	// ------------------------------------------------------------------
	localparam logic [7:0] CPD_RST_PD1  = 8'hff;
	localparam logic [7:0] CPD_RST_PD2  = 8'h84;
	localparam logic [7:0] CPD_RST_PD3  = 8'h20;
	localparam logic [7:0] CPD_MASK_PD1 = 8'hfd;      // Bit 1 is reserved.
	localparam logic [7:0] CPD_MASK_PD2 = 8'h1f;      // Bits 7:5 are reserved.
	localparam logic [7:0] CPD_MASK_PD3 = 8'h66;      // Bits 7, 4:3 and 0 are reserved.
	localparam logic [7:0] CPD_RD_NONE  = 8'h00;      // Answer for an unmapped read.

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int CPD_B_SER_OUT   = 7;
	localparam int CPD_B_SER_IN    = 6;
	localparam int CPD_B_MIX       = 5;
	localparam int CPD_B_EQ        = 4;
	localparam int CPD_B_HP_DAC    = 3;
	localparam int CPD_B_ADC       = 2;
	localparam int CPD_B_GLOBAL    = 0;
	localparam int CPD_B_DISCHARGE = 4;
	localparam int CPD_B_OVERRIDE  = 3;
	localparam int CPD_B_IN_CH1    = 2;
	localparam int CPD_B_PB_CONV   = 1;
	localparam int CPD_B_CAP_CONV  = 0;
	localparam int CPD_B_SEL_HI    = 6;
	localparam int CPD_B_SEL_LO    = 5;
	localparam int CPD_B_SUPPLY    = 2;
	localparam int CPD_B_RING      = 1;

	// Clock-stop report selections.
	localparam logic [1:0] CPD_SEL_NONE    = 2'h0;
	localparam logic [1:0] CPD_SEL_FULL    = 2'h1;
	localparam logic [1:0] CPD_SEL_PARTIAL = 2'h2;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CPD_CLK_PERIOD_NS = 10;
	localparam int CPD_PDN_SETTLE_NS = 1000;          // Wait for blocks to wind down.
	localparam int CPD_DISCHARGE_US  = 46000;         // Filter capacitor discharge time.
	localparam int CPD_PDN_SETTLE_CYC =
		(CPD_PDN_SETTLE_NS + CPD_CLK_PERIOD_NS - 1) / CPD_CLK_PERIOD_NS;
	localparam int CPD_DISCHARGE_CYC =
		(CPD_DISCHARGE_US * 1000 + CPD_CLK_PERIOD_NS - 1) / CPD_CLK_PERIOD_NS;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	// One register access from the control port.
	typedef struct packed {
		logic        wr;        // Write strobe, one cycle.
		logic        rd;        // Read strobe, one cycle.
		logic [15:0] addr;      // Register address.
		logic [7:0]  wdata;     // Write data.
	} cpd_reg_req_t;

	// Power state handed to the analog and digital subblocks.
	typedef struct packed {
		logic serial_out_path_off;
		logic serial_in_path_off;
		logic mix_block_off;
		logic equalizer_off;
		logic equalizer_reset;
		logic headphone_dac_off;
		logic capture_converter_off;
		logic in_channel1_off;
		logic playback_rate_conv_on;
		logic capture_rate_conv_on;
		logic supply_monitor_on;
		logic ring_detect_on;
		logic filter_cap_discharge;
	} cpd_power_t;

endpackage : cpd_pkg

`default_nettype wire

// ===== src/cpd_power_ctrl.sv
// Register-driven power-down control for the codec subblocks.
`default_nettype none
`timescale 1ns/10ps

module cpd_power_ctrl #(
	parameter int DISCHARGE_CYCLES = cpd_pkg::CPD_DISCHARGE_CYC
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire cpd_pkg::cpd_reg_req_t reg_req,
	output var  logic [7:0]            reg_rdata,
	output var  logic                  reg_rvalid,
	input  wire logic                  freeze,
	input  wire logic                  playback_conv_bypass,
	input  wire logic                  capture_conv_bypass,
	input  wire logic                  bus_select_pin,
	input  wire logic                  input_channel_zero_en,
	input  wire logic                  output_channel_en,
	input  wire logic                  transmitter_off,
	input  wire logic                  headset_detect_idle,
	input  wire logic                  mic_bias_off,
	input  wire logic                  clock_stop_request,
	output var  cpd_pkg::cpd_power_t   power,
	output var  logic                  serial_data_output_oe_n,
	output var  logic                  power_down_done,
	output var  logic                  filter_discharged,
	output var  logic                  clock_stop_pending
);

	import cpd_pkg::*;

	// ------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------
	// The shadow copy holds what software last wrote and is what reads
	// return; the live copy is what actually drives the power controls.
	logic [7:0] shadow_r [3];          // Written values, index 0..2.
	logic [7:0] live_r   [3];          // Applied values, index 0..2.
	logic [7:0] live_nxt [3];          // Next applied values.
	logic [7:0] shadow_nxt [3];        // Next written values.

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	wire logic [2:0] hit;              // One-hot register select.
	wire logic       any_hit;          // Address maps to a register.
	wire logic [7:0] masked_wdata [3]; // Write data with reserved bits restored.
	wire logic [7:0] rd_mux;           // Selected read value.

	assign hit[0]  = (reg_req.addr == CPD_OFS_PD1);
	assign hit[1]  = (reg_req.addr == CPD_OFS_PD2);
	assign hit[2]  = (reg_req.addr == CPD_OFS_PD3);
	assign any_hit = |hit;

	assign masked_wdata[0] = (reg_req.wdata & CPD_MASK_PD1) | (CPD_RST_PD1 & ~CPD_MASK_PD1);
	assign masked_wdata[1] = (reg_req.wdata & CPD_MASK_PD2) | (CPD_RST_PD2 & ~CPD_MASK_PD2);
	assign masked_wdata[2] = (reg_req.wdata & CPD_MASK_PD3) | (CPD_RST_PD3 & ~CPD_MASK_PD3);

	assign rd_mux = hit[0] ? shadow_r[0] :
	                hit[1] ? shadow_r[1] :
	                hit[2] ? shadow_r[2] : CPD_RD_NONE;

	// ------------------------------------------------------------------
	// Write path with freeze
	// ------------------------------------------------------------------
	// Each register follows the same pattern, so one loop builds all three.
	// A write lands in the shadow at once. With freeze low it also reaches
	// the live copy in the same edge; with freeze high the live copy keeps
	// its value and catches up with the shadow in the cycle freeze drops.
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_reg
			wire logic wr_here;        // Write aimed at this register.
			assign wr_here          = reg_req.wr && hit[gi];
			assign shadow_nxt[gi]   = wr_here ? masked_wdata[gi] : shadow_r[gi];
			assign live_nxt[gi]     = freeze ? live_r[gi] : shadow_nxt[gi];
		end
	endgenerate

	// Register update; reset loads the documented defaults.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			shadow_r[0] <= CPD_RST_PD1;
			shadow_r[1] <= CPD_RST_PD2;
			shadow_r[2] <= CPD_RST_PD3;
			live_r[0]   <= CPD_RST_PD1;
			live_r[1]   <= CPD_RST_PD2;
			live_r[2]   <= CPD_RST_PD3;
		end else begin
			shadow_r <= shadow_nxt;
			live_r   <= live_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	// Reads answer one cycle after the strobe; an unmapped address reads zero.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata  <= CPD_RD_NONE;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata  <= reg_req.rd ? rd_mux : reg_rdata;
			reg_rvalid <= reg_req.rd;
		end
	end

	// ------------------------------------------------------------------
	// Pin synchroniser for the bus-select strap
	// ------------------------------------------------------------------
	logic bus_sel_meta_r;              // First stage, read only by the second.
	logic bus_sel_r;                   // Safe to use from here on.

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bus_sel_meta_r <= 1'b0;
			bus_sel_r      <= 1'b0;
		end else begin
			bus_sel_meta_r <= bus_select_pin;
			bus_sel_r      <= bus_sel_meta_r;
		end
	end

	// ------------------------------------------------------------------
	// Field decode of the applied registers
	// ------------------------------------------------------------------
	wire logic       global_pd;        // Whole codec held down.
	wire logic       conv_override;    // Manual converter control.
	wire logic [1:0] report_sel;       // Clock-stop report selection.

	assign global_pd     = live_r[0][CPD_B_GLOBAL];
	assign conv_override = live_r[1][CPD_B_OVERRIDE];
	assign report_sel    = live_r[2][CPD_B_SEL_HI:CPD_B_SEL_LO];

	// ------------------------------------------------------------------
	// Subblock power decisions
	// ------------------------------------------------------------------
	// Global power-down overrides every path bit, but the transmitter power
	// and PLL start are not in this block so keep-alive operation survives.
	// When global clears, each path falls back to its own bit; input channel 1 also follows the serial input path bit.
	wire logic ser_out_off;
	wire logic ser_in_off;
	wire logic mix_off;
	wire logic eq_off;
	wire logic hp_dac_off;
	wire logic adc_off;
	wire logic ch1_off;

	assign ser_out_off = global_pd | live_r[0][CPD_B_SER_OUT];
	assign ser_in_off  = global_pd | live_r[0][CPD_B_SER_IN];
	assign mix_off     = global_pd | live_r[0][CPD_B_MIX];
	assign eq_off      = global_pd | live_r[0][CPD_B_EQ];
	assign hp_dac_off  = global_pd | live_r[0][CPD_B_HP_DAC];
	assign adc_off     = global_pd | live_r[0][CPD_B_ADC];
	assign ch1_off     = global_pd | live_r[1][CPD_B_IN_CH1] | live_r[0][CPD_B_SER_IN];

	// ------------------------------------------------------------------
	// Sample-rate converter policy
	// ------------------------------------------------------------------
	wire logic pb_auto_on;             // Playback converters, automatic policy.
	wire logic cap_auto_on;            // Capture converter, automatic policy.
	wire logic pb_conv_on;             // Playback converters, final.
	wire logic cap_conv_on;            // Capture converter, final.

	assign pb_auto_on  = !global_pd && !playback_conv_bypass &&
	                     (bus_sel_r || input_channel_zero_en);
	assign cap_auto_on = !global_pd && !capture_conv_bypass &&
	                     (bus_sel_r || output_channel_en);

	// The override bypasses the policy completely, including global power-down,
	// so software owns the converters while it is set.
	// override follows bits
	assign pb_conv_on  = conv_override ? live_r[1][CPD_B_PB_CONV]  : pb_auto_on;
	assign cap_conv_on = conv_override ? live_r[1][CPD_B_CAP_CONV] : cap_auto_on;

	// ------------------------------------------------------------------
	// Filter discharge
	// ------------------------------------------------------------------
	// The clamp is only honoured during global power-down; outside it the
	// bit is stored but kept off the pin to protect a running reference.
	wire logic discharge_on;

	assign discharge_on = global_pd & live_r[1][CPD_B_DISCHARGE];

	cpd_hold_timer #(
		.CYCLES (DISCHARGE_CYCLES)
	) u_discharge_timer (
		.sys_clk (sys_clk),
		.rst     (rst),
		.level   (discharge_on),
		.done    (filter_discharged)
	);

	// ------------------------------------------------------------------
	// Power-down completion
	// ------------------------------------------------------------------
	// Done rises once global power-down has held for the settle time and
	// falls as soon as global power-down is released.
	// done after settle
	cpd_hold_timer #(
		.CYCLES (CPD_PDN_SETTLE_CYC)
	) u_settle_timer (
		.sys_clk (sys_clk),
		.rst     (rst),
		.level   (global_pd),
		.done    (power_down_done)
	);

	// ------------------------------------------------------------------
	// Clock-stop reporting
	// ------------------------------------------------------------------
	// The selection only says what must be down; the block never issues
	// the power-down writes itself.
	wire logic full_down;              // Every block of the full set is down.
	wire logic partial_down;           // ADC, headphone and transmitter down.
	wire logic report_ready;           // Selected set is down.
	wire logic pending_nxt;

	assign full_down    = hp_dac_off && adc_off && transmitter_off &&
	                      headset_detect_idle && mic_bias_off;
	assign partial_down = adc_off && hp_dac_off && transmitter_off;

	assign report_ready = (report_sel == CPD_SEL_NONE)    ? 1'b1 :
	                      (report_sel == CPD_SEL_PARTIAL) ? partial_down :
	                      full_down;

	// A new request wins over a clear in the same cycle.
	assign pending_nxt = clock_stop_request | (clock_stop_pending & ~report_ready);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			clock_stop_pending <= 1'b0;
		end else begin
			clock_stop_pending <= pending_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------------
	cpd_power_t power_nxt;             // Next state of the power bundle.

	// Collect every decision into the bundle that the subblocks see.
	always_comb begin
		power_nxt                       = '0;
		power_nxt.serial_out_path_off   = ser_out_off;
		power_nxt.serial_in_path_off    = ser_in_off;
		power_nxt.mix_block_off         = mix_off;
		power_nxt.equalizer_off         = eq_off;
		power_nxt.equalizer_reset       = eq_off;
		power_nxt.headphone_dac_off     = hp_dac_off;
		power_nxt.capture_converter_off = adc_off;
		power_nxt.in_channel1_off       = ch1_off;
		power_nxt.playback_rate_conv_on = pb_conv_on;
		power_nxt.capture_rate_conv_on  = cap_conv_on;
		power_nxt.supply_monitor_on     = live_r[2][CPD_B_SUPPLY] & ~global_pd;
		power_nxt.ring_detect_on        = live_r[2][CPD_B_RING] & ~global_pd;
		power_nxt.filter_cap_discharge  = discharge_on;
	end

	// Reset clears every bit of the power bundle and releases the serial data pin; the
	// serial clock pins are outside this block and never tristated here.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			power                   <= '0;
			serial_data_output_oe_n <= 1'b1;
		end else begin
			power                   <= power_nxt;
			serial_data_output_oe_n <= ser_out_off;
		end
	end

endmodule // cpd_power_ctrl

`default_nettype wire

// ===== verif/cpd_host_model.sv
// Behavioural host issuing register accesses on the control port.
`timescale 1ns/10ps
`default_nettype none
module cpd_host_model (
	input  wire logic                  sys_clk,
	output var  cpd_pkg::cpd_reg_req_t reg_req,
	input  wire logic [7:0]            reg_rdata,
	input  wire logic                  reg_rvalid
);
	import cpd_pkg::*;
	logic global_r = 1'b1;  // Last global power-down written.
	logic latch_r = 1'b0;   // Supply latch, enabled by the host before any global power-down.
	initial reg_req = '0;
	// One write; idle bus is scrambled so stale values never look valid.
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		if (a == CPD_OFS_PD2 && !global_r) d[CPD_B_DISCHARGE] = 1'b0;
		if (a == CPD_OFS_PD1 && d[CPD_B_GLOBAL] && !latch_r) latch_r = 1'b1;
		if (a == CPD_OFS_PD1) global_r = d[CPD_B_GLOBAL];
		@(negedge sys_clk);
		reg_req.wr = 1'b1;
		reg_req.addr = a;
		reg_req.wdata = d;
		@(negedge sys_clk);
		reg_req.wr = 1'b0;
		reg_req.addr = ~a;
		reg_req.wdata = ~d;
	endtask
	// One read; the answer is awaited for a bounded number of cycles.
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(negedge sys_clk);
		reg_req.rd = 1'b1;
		reg_req.addr = a;
		@(negedge sys_clk);
		reg_req.rd = 1'b0;
		reg_req.addr = ~a;
		// The answer stands for one cycle only, from the edge that took the
		// strobe, so it is looked at before the next falling edge is awaited.
		for (int i = 0; i < 4 && !ok; i++) begin
			if (reg_rvalid === 1'b1) begin
				ok = 1'b1;
				d = reg_rdata;
			end else begin
				@(negedge sys_clk);
			end
		end
	endtask
endmodule // cpd_host_model
`default_nettype wire

// ===== verif/cpd_power_ctrl_properties.sv
// Checker of the power-down control's port behaviour.
`timescale 1ns/10ps
`default_nettype none
module cpd_power_ctrl_chk #(
	parameter int DISCHARGE_CYCLES = 20
) (
	input wire logic                  sys_clk,
	input wire logic                  rst,
	input wire cpd_pkg::cpd_reg_req_t reg_req,
	input wire logic [7:0]            reg_rdata,
	input wire logic                  reg_rvalid,
	input wire logic                  clock_stop_request,
	input wire cpd_pkg::cpd_power_t   power,
	input wire logic                  serial_data_output_oe_n,
	input wire logic                  power_down_done,
	input wire logic                  filter_discharged,
	input wire logic                  clock_stop_pending
);
	import cpd_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Run length of the clamp; a short clamp must not report discharged.
	logic [31:0] clamp_cnt_r;
	logic [31:0] clamp_cnt_nxt;
	assign clamp_cnt_nxt = power.filter_cap_discharge ? clamp_cnt_r + 32'h1 : 32'h0;
	always_ff @(posedge sys_clk) begin
		clamp_cnt_r <= rst ? 32'h0 : clamp_cnt_nxt;
	end
	rd_answer_a: assert property (reg_req.rd |=> reg_rvalid)
		else $error("read strobe got no answer");
	rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_req.rd))
		else $error("answer without a read");
	rdata_hold_a: assert property (!reg_rvalid |-> $stable(reg_rdata))
		else $error("read data moved between reads");
	out_hiz_a: assert property (power.serial_out_path_off |-> ##[0:1] serial_data_output_oe_n)
		else $error("data output driven while path off");
	out_drive_a: assert property ($fell(power.serial_out_path_off) |-> ##[0:1] !serial_data_output_oe_n)
		else $error("data output not driven after power up");
	eq_reset_a: assert property (power.equalizer_reset == power.equalizer_off)
		else $error("equalizer reset differs from its power");
	ch1_off_a: assert property (power.serial_in_path_off |-> power.in_channel1_off)
		else $error("channel one on with input path off");
	done_off_a: assert property ($rose(power_down_done) |-> power.mix_block_off
		&& power.headphone_dac_off && power.capture_converter_off)
		else $error("done raised with blocks powered");
	clamp_time_a: assert property ($rose(filter_discharged) |->
		power.filter_cap_discharge && clamp_cnt_r + 3 >= DISCHARGE_CYCLES)
		else $error("discharged raised too early");
	stop_req_a: assert property (clock_stop_request |=> clock_stop_pending)
		else $error("clock stop request not taken");
	cover property (reg_rvalid);
	cover property ($rose(power_down_done));
	cover property ($rose(filter_discharged));
	cover property ($fell(clock_stop_pending));
endmodule // cpd_power_ctrl_chk

bind cpd_power_ctrl cpd_power_ctrl_chk #(.DISCHARGE_CYCLES(DISCHARGE_CYCLES)) i_chk (
	.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .clock_stop_request(clock_stop_request), .power(power),
	.serial_data_output_oe_n(serial_data_output_oe_n), .power_down_done(power_down_done),
	.filter_discharged(filter_discharged), .clock_stop_pending(clock_stop_pending)
);
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the codec power-down control.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import cpd_pkg::*;
	localparam int DIS_CYC = 20;  // Shortened clamp time keeps the run brief.
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	cpd_reg_req_t reg_req;
	cpd_power_t power;
	logic [7:0] reg_rdata, pd1, pd2, pd3, rv;
	logic reg_rvalid, oe_n, done, discharged, pending, ok;
	logic freeze, pb_byp, cap_byp, bus_sel, ch0_en, out_en, tx_off, hs_idle, mic_off, stop_req;
	int n_mismatch = 0;
	int cmp_count = 0;
	always #5 sys_clk = ~sys_clk;
	cpd_power_ctrl #(.DISCHARGE_CYCLES(DIS_CYC)) i_cpd_power_ctrl (
		.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .freeze(freeze), .playback_conv_bypass(pb_byp),
		.capture_conv_bypass(cap_byp), .bus_select_pin(bus_sel),
		.input_channel_zero_en(ch0_en), .output_channel_en(out_en), .transmitter_off(tx_off),
		.headset_detect_idle(hs_idle), .mic_bias_off(mic_off), .clock_stop_request(stop_req),
		.power(power), .serial_data_output_oe_n(oe_n), .power_down_done(done),
		.filter_discharged(discharged), .clock_stop_pending(pending));
	cpd_host_model i_cpd_host_model (.sys_clk(sys_clk), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	task automatic test_done();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Read and compare; a lost answer ends the run.
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
		i_cpd_host_model.rd(a, rv, ok);
		if (ok !== 1'b1) begin
			check("read answer", 16'h0, 16'h1);
			test_done();
		end
		check("read data", 16'(rv), 16'(exp));
	endtask
	function automatic logic flag(input int k);
		return k == 0 ? done : (k == 1 ? discharged : pending);
	endfunction
	// Bounded wait for a flag level; running out ends the run.
	task automatic wait_flag(input int k, input logic lvl, input int n);
		for (int i = 0; i < n && flag(k) !== lvl; i++) @(negedge sys_clk);
		check("flag wait", 16'(flag(k)), 16'(lvl));
		if (flag(k) !== lvl) test_done();
	endtask
	// Expected power state; global forces all but override-held converters and the clamp off.
	function automatic cpd_power_t exp_pwr(input logic [7:0] p1, input logic [7:0] p2,
		input logic [7:0] p3);
		cpd_power_t e;
		logic g;
		g = p1[0];
		e = {p1[7] | g, p1[6] | g, p1[5] | g, p1[4] | g, p1[4] | g, p1[3] | g, p1[2] | g,
			p2[2] | p1[6] | g,
			p2[3] ? p2[1] : !g && !pb_byp && (bus_sel || ch0_en),
			p2[3] ? p2[0] : !g && !cap_byp && (bus_sel || out_en),
			p3[2] & !g, p3[1] & !g, p2[4] & g};
		return e;
	endfunction
	initial begin
		{freeze, pb_byp, cap_byp, bus_sel, ch0_en, out_en} = '0;
		{tx_off, hs_idle, mic_off, stop_req} = '0;
		void'($urandom(29024));
		repeat (10) @(negedge sys_clk);
		rst = 1'b0;
		rd_chk(CPD_OFS_PD1, CPD_RST_PD1);
		rd_chk(CPD_OFS_PD2, CPD_RST_PD2);
		rd_chk(CPD_OFS_PD3, CPD_RST_PD3);
		rd_chk(16'h1104, CPD_RD_NONE);
		check("reset power", 16'(power), 16'(exp_pwr(CPD_RST_PD1, CPD_RST_PD2, CPD_RST_PD3)));
		check("reset hi-z", 16'(oe_n), 16'h1);
		wait_flag(0, 1'b1, 120);
		// Two override corners first, then random mixes; clamp stays clear here.
		for (int k = 0; k < 24; k++) begin
			pd1 = k == 0 ? 8'h00 : (k == 1 ? 8'h41 : 8'($urandom()));
			pd2 = k < 2 ? 8'h0b : 8'($urandom()) & 8'hef;
			pd3 = 8'($urandom());
			{pb_byp, cap_byp, bus_sel, ch0_en, out_en} = 5'($urandom());
			i_cpd_host_model.wr(CPD_OFS_PD2, pd2);
			i_cpd_host_model.wr(CPD_OFS_PD3, pd3);
			i_cpd_host_model.wr(CPD_OFS_PD1, pd1);
			repeat (6) @(negedge sys_clk);
			rd_chk(CPD_OFS_PD1, (pd1 & CPD_MASK_PD1) | (CPD_RST_PD1 & ~CPD_MASK_PD1));
			rd_chk(CPD_OFS_PD2, (pd2 & CPD_MASK_PD2) | (CPD_RST_PD2 & ~CPD_MASK_PD2));
			rd_chk(CPD_OFS_PD3, (pd3 & CPD_MASK_PD3) | (CPD_RST_PD3 & ~CPD_MASK_PD3));
			check("power map", 16'(power), 16'(exp_pwr(pd1, pd2, pd3)));
			check("data hi-z", 16'(oe_n), 16'(pd1[7] | pd1[0]));
		end
		// A held write lands only when the hold lifts.
		i_cpd_host_model.wr(CPD_OFS_PD1, 8'hff);
		freeze = 1'b1;
		i_cpd_host_model.wr(CPD_OFS_PD1, 8'h00);
		repeat (4) @(negedge sys_clk);
		check("frozen", 16'(power), 16'(exp_pwr(8'hff, pd2, pd3)));
		rd_chk(CPD_OFS_PD1, 8'h02);
		freeze = 1'b0;
		repeat (4) @(negedge sys_clk);
		check("thawed", 16'(power), 16'(exp_pwr(8'h00, pd2, pd3)));
		// Done waits out the settle count; the clamp waits its own.
		i_cpd_host_model.wr(CPD_OFS_PD1, 8'h01);
		repeat (60) @(negedge sys_clk);
		check("early done", 16'(done), 16'h0);
		wait_flag(0, 1'b1, 60);
		i_cpd_host_model.wr(CPD_OFS_PD2, 8'h10);
		repeat (DIS_CYC / 2) @(negedge sys_clk);
		check("early clamp", 16'(discharged), 16'h0);
		wait_flag(1, 1'b1, DIS_CYC);
		check("clamp", 16'(power.filter_cap_discharge), 16'h1);
		i_cpd_host_model.wr(CPD_OFS_PD2, 8'h00);
		i_cpd_host_model.wr(CPD_OFS_PD1, 8'h00);
		wait_flag(0, 1'b0, 4);
		// Each report selection against a staged power-down; code 3 acts as the full set.
		for (int s = 0; s < 4; s++) begin
			{tx_off, hs_idle, mic_off} = 3'h0;
			i_cpd_host_model.wr(CPD_OFS_PD1, 8'h00);
			i_cpd_host_model.wr(CPD_OFS_PD3, 8'(s << 5));
			stop_req = 1'b1;
			@(negedge sys_clk);
			stop_req = 1'b0;
			repeat (4) @(negedge sys_clk);
			check("pending", 16'(pending), 16'(s != 0));
			// Host powers the chosen blocks down itself.
			i_cpd_host_model.wr(CPD_OFS_PD1, 8'h0c);
			tx_off = 1'b1;
			repeat (4) @(negedge sys_clk);
			check("pending part", 16'(pending), 16'(s == 1 || s == 3));
			// Headset detect finished before the stop.
			{hs_idle, mic_off} = 2'h3;
			wait_flag(2, 1'b0, 6);
		end
		test_done();
	end
endmodule // tb_top
`default_nettype wire
